/* File: piop_port.sv */
`timescale 1ns/100ps
// How it works
// - shared peripheral output beats the port
// - peripheral driving: port driver off, pin readable
// - enabled but idle peripheral lets port drive
// - port output never loops into peripheral
// - direction bit 1 input, 0 output
// - reset makes every pin an input
// - latch reads back, writes update it
// - level reads pins, writes hit latch
// - unimplemented bits read as zero
// - open-drain select forces open-drain drive
// - analog pins read low
// - enabled input change raises interrupt
// - twenty-two change inputs, 0 to 21
// - per-input change interrupt enable bit
// - per-change-input weak pull-up enable bit, 0 to 21
// - input-only sharing leaves the pin to the port
module piop_port
  import piop_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // software side
  input  wire piop_sw_t           sw_i,
  input  wire logic [PIOP_W-1:0]  analog_cfg_i,
  input  wire logic [PIOP_CN-1:0] cn_irq_en_i,
  input  wire logic [PIOP_CN-1:0] pullup_en_i,
  input  wire logic [PIOP_CN-1:0] cn_clr_i,
  output logic      [PIOP_W-1:0]  dir_o,
  output logic      [PIOP_W-1:0]  lat_o,
  output logic      [PIOP_W-1:0]  odc_o,
  output logic      [PIOP_W-1:0]  pin_level_o,
  output logic      [PIOP_CN-1:0] cn_flag_o,
  output logic                    irq_o,
  // shared peripheral
  input  wire piop_periph_t       periph_i,
  output logic      [PIOP_W-1:0]  periph_in_o,
  // pins
  input  wire logic [PIOP_W-1:0]  pin_i,
  output logic      [PIOP_W-1:0]  pin_o,
  output logic      [PIOP_W-1:0]  pin_oe_o,
  input  wire logic [PIOP_CN-1:0] cn_i,
  output logic      [PIOP_CN-1:0] pullup_o
);

  piop_state_t s_q;
  piop_state_t s_d;

  logic [PIOP_W-1:0]  own_periph;
  logic [PIOP_W-1:0]  port_drv;
  logic [PIOP_W-1:0]  out_val;
  logic [PIOP_W-1:0]  out_drv;
  logic [PIOP_CN-1:0] cn_change;

  ////////////////////////////////////////////////////////////////////////////
  // shared decodes
  function automatic logic [PIOP_W-1:0] owned_pins(input piop_periph_t p);
    return p.en & p.drive;
  endfunction

  // unimplemented bits must never hold a one
  function automatic logic [PIOP_W-1:0] impl_only(input logic [PIOP_W-1:0] v);
    return v & PIOP_IMPL_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ownership of each pin
  always_comb begin
    // only an active driver takes the pin; input-only use leaves it to the port
    own_periph = owned_pins(periph_i);
    port_drv   = ~own_periph & ~s_q.dir;
    out_val    = (own_periph & periph_i.data) | (~own_periph & s_q.lat);
    out_drv    = (own_periph | port_drv) & PIOP_IMPL_MASK;
  end

  // change detection; compare held off until the sync chain holds real samples
  always_comb begin
    cn_change = '0;
    if (s_q.cn_arm == PIOP_CN_ARM_CNT) begin
      cn_change = (s_q.cn_s2 ^ s_q.cn_prev) & cn_irq_en_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;

    // software writes, masked to the implemented bits
    if (sw_i.wr_dir) begin
      s_d.dir = impl_only(sw_i.wdata);
    end
    if (sw_i.wr_odc) begin
      s_d.odc = impl_only(sw_i.wdata);
    end
    // a level-register write lands in the latch; a latch write wins a tie
    if (sw_i.wr_lat) begin
      s_d.lat = impl_only(sw_i.wdata);
    end else if (sw_i.wr_lvl) begin
      s_d.lat = impl_only(sw_i.wdata);
    end

    // pin synchronisers
    s_d.pin_s1 = pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    // analog pins read low whatever their voltage
    s_d.pin_lvl = s_q.pin_s2 & ~analog_cfg_i & PIOP_IMPL_MASK;

    // pin drive; open-drain only ever pulls low
    s_d.pin_out = out_val & ~s_q.odc & out_drv;
    s_d.pin_oe  = out_drv & (~s_q.odc | ~out_val);

    // peripheral sees the pin only where the port is not driving it
    s_d.periph_in = s_q.pin_s2 & ~port_drv & PIOP_IMPL_MASK;

    // pull-ups
    s_d.pu = pullup_en_i;

    // change notification; a new change beats a clear in the same cycle
    s_d.cn_s1   = cn_i;
    s_d.cn_s2   = s_q.cn_s1;
    s_d.cn_prev = s_q.cn_s2;
    s_d.cn_flag = (s_q.cn_flag & ~cn_clr_i) | cn_change;
    s_d.irq     = |s_d.cn_flag;
    if (s_q.cn_arm != PIOP_CN_ARM_CNT) begin
      s_d.cn_arm = s_q.cn_arm + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_q.dir       <= PIOP_DIR_RST & PIOP_IMPL_MASK;
      s_q.lat       <= PIOP_LAT_RST;
      s_q.odc       <= PIOP_ODC_RST;
      s_q.pin_s1    <= '0;
      s_q.pin_s2    <= '0;
      s_q.pin_lvl   <= '0;
      s_q.pin_out   <= '0;
      s_q.pin_oe    <= '0;
      s_q.periph_in <= '0;
      s_q.pu        <= PIOP_CN_RST;
      s_q.cn_s1     <= PIOP_CN_RST;
      s_q.cn_s2     <= PIOP_CN_RST;
      s_q.cn_prev   <= PIOP_CN_RST;
      s_q.cn_flag   <= PIOP_CN_RST;
      s_q.cn_arm    <= 2'h0;
      s_q.irq       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  // limitation: detection needs this clock; sleep wake-up must keep it running
  assign dir_o       = s_q.dir;
  assign lat_o       = s_q.lat;
  assign odc_o       = s_q.odc;
  assign pin_level_o = s_q.pin_lvl;
  assign cn_flag_o   = s_q.cn_flag;
  assign irq_o       = s_q.irq;
  assign periph_in_o = s_q.periph_in;
  assign pin_o       = s_q.pin_out;
  assign pin_oe_o    = s_q.pin_oe;
  assign pullup_o    = s_q.pu;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  property p_dir_reset;
    $past(reset_i) |-> (dir_o == (PIOP_DIR_RST & PIOP_IMPL_MASK)) && (pin_oe_o == '0);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not all inputs after reset");

  property p_periph_owns;
    !$past(reset_i) |=>
      ((pin_o ^ ($past(periph_i.data) & ~$past(odc_o)))
       & $past(periph_i.en & periph_i.drive) & PIOP_IMPL_MASK) == '0;
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("peripheral data not on owned pin");

  property p_port_idle_periph;
    !$past(reset_i) |=>
      ((pin_oe_o ^ ~($past(odc_o) & $past(lat_o)))
       & $past(periph_i.en & ~periph_i.drive & ~dir_o) & PIOP_IMPL_MASK) == '0;
  endproperty
  a_port_idle_periph: assert property (p_port_idle_periph)
    else $error("port not driving beside idle peripheral");

  property p_input_floats;
    !$past(reset_i) |=>
      (pin_oe_o & $past(dir_o & ~(periph_i.en & periph_i.drive))) == '0;
  endproperty
  a_input_floats: assert property (p_input_floats)
    else $error("input pin driven");

  property p_lat_write;
    sw_i.wr_lat |=> lat_o == (($past(sw_i.wdata)) & PIOP_IMPL_MASK);
  endproperty
  a_lat_write: assert property (p_lat_write)
    else $error("latch write lost");

  property p_lvl_write;
    sw_i.wr_lvl && !sw_i.wr_lat |=> lat_o == ($past(sw_i.wdata) & PIOP_IMPL_MASK);
  endproperty
  a_lvl_write: assert property (p_lvl_write)
    else $error("level write did not reach latch");

  property p_dir_write;
    sw_i.wr_dir |=> dir_o == ($past(sw_i.wdata) & PIOP_IMPL_MASK);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");

  property p_odc_write;
    sw_i.wr_odc |=> odc_o == ($past(sw_i.wdata) & PIOP_IMPL_MASK);
  endproperty
  a_odc_write: assert property (p_odc_write)
    else $error("open-drain select write lost");

  // a plain output pin carries the latch
  property p_port_drive;
    !$past(reset_i) |=>
      ((~pin_oe_o | (pin_o ^ $past(lat_o)))
       & $past(~dir_o & ~odc_o & ~owned_pins(periph_i)) & PIOP_IMPL_MASK) == '0;
  endproperty
  a_port_drive: assert property (p_port_drive)
    else $error("output pin not driving latch");

  property p_lvl_read;
    !$past(reset_i, 3) |->
      pin_level_o == ($past(pin_i, 3) & ~$past(analog_cfg_i) & PIOP_IMPL_MASK);
  endproperty
  a_lvl_read: assert property (p_lvl_read)
    else $error("level read wrong");

  property p_unimpl_zero;
    ((dir_o | lat_o | pin_level_o | pin_oe_o) & ~PIOP_IMPL_MASK) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit not zero");

  property p_open_drain;
    !$past(reset_i) |=> (pin_o & $past(odc_o)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high");

  property p_no_loop;
    !$past(reset_i) |=>
      (periph_in_o & $past(~dir_o & ~(periph_i.en & periph_i.drive))) == '0;
  endproperty
  a_no_loop: assert property (p_no_loop)
    else $error("port output looped into peripheral");

  // pin to peripheral takes three edges, like the level path
  property p_periph_in;
    !$past(reset_i, 3) |->
      periph_in_o ==
        ($past(pin_i, 3) & $past(dir_o | owned_pins(periph_i)) & PIOP_IMPL_MASK);
  endproperty
  a_periph_in: assert property (p_periph_in)
    else $error("pin level not passed to peripheral");

  property p_analog_low;
    !$past(reset_i) |-> (pin_level_o & $past(analog_cfg_i)) == '0;
  endproperty
  a_analog_low: assert property (p_analog_low)
    else $error("analog pin read high");

  // compare fires two edges after the change reaches the first flop
  sequence s_cn_seen;
    (s_q.cn_arm == PIOP_CN_ARM_CNT) ##2
      ((cn_irq_en_i & ($past(cn_i, 2) ^ $past(cn_i, 3))) != '0);
  endsequence
  property p_cn_irq;
    s_cn_seen |=> irq_o && (cn_flag_o != '0);
  endproperty
  a_cn_irq: assert property (p_cn_irq)
    else $error("enabled change gave no interrupt");

  property p_cn_enable;
    ((cn_flag_o & ~$past(cn_flag_o)) & ~$past(cn_irq_en_i)) == '0;
  endproperty
  a_cn_enable: assert property (p_cn_enable)
    else $error("flag set on disabled input");

  property p_set_wins;
    !$past(reset_i) |->
      ($past(cn_change) & ~cn_flag_o) == '0;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("detected change dropped");

  property p_pullup;
    !$past(reset_i) |-> pullup_o == $past(pullup_en_i);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable not applied");

  property p_irq_low;
    (cn_flag_o == '0) && !$past(reset_i) |-> !irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt without flag");

  // flags are sticky: only a clear drops one, only a change raises one
  property p_flag_hold;
    !$past(reset_i) |-> ($past(cn_flag_o) & ~$past(cn_clr_i) & ~cn_flag_o) == '0;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

  property p_flag_clear;
    !$past(reset_i) |-> (cn_flag_o & $past(cn_clr_i) & ~$past(cn_change)) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("cleared flag stayed set");

  property p_irq_high;
    (cn_flag_o != '0) |-> irq_o;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("flag without interrupt");

  c_periph_take: cover property ((periph_i.en & periph_i.drive) != '0 ##1 pin_oe_o != '0);
  c_cn_irq:      cover property (s_cn_seen ##1 irq_o);
  c_clr_tie:     cover property ((cn_change & cn_clr_i) != '0);
  c_open_drain:  cover property ((pin_oe_o & odc_o) != '0);
  c_lvl_write:   cover property (sw_i.wr_lvl ##1 lat_o != '0);

endmodule

/* File: piop_pkg.sv */
package piop_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int PIOP_W  = 16;
  localparam int PIOP_CN = 22;

  ////////////////////////////////////////////////////////////////////////////
  // implemented-bit mask of this variant; plain default, all bits present
  localparam logic [PIOP_W-1:0] PIOP_IMPL_MASK = 16'hffff;

  // reset values
  localparam logic [PIOP_W-1:0]  PIOP_DIR_RST  = 16'hffff;
  localparam logic [PIOP_W-1:0]  PIOP_LAT_RST  = 16'h0000;
  localparam logic [PIOP_W-1:0]  PIOP_ODC_RST  = 16'h0000;
  localparam logic [PIOP_CN-1:0] PIOP_CN_RST   = 22'h000000;

  // direction bit encoding
  localparam logic PIOP_DIR_IN  = 1'b1;
  localparam logic PIOP_DIR_OUT = 1'b0;

  // cycles after reset before the change comparator is trusted
  localparam logic [1:0] PIOP_CN_ARM_CNT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // software write strobes with their data
  typedef struct packed {
    logic              wr_dir;
    logic              wr_lat;
    logic              wr_lvl;
    logic              wr_odc;
    logic [PIOP_W-1:0] wdata;
  } piop_sw_t;

  // peripheral sharing the pins
  typedef struct packed {
    logic [PIOP_W-1:0] en;
    logic [PIOP_W-1:0] drive;
    logic [PIOP_W-1:0] data;
  } piop_periph_t;

  // all state of the port
  typedef struct packed {
    logic [PIOP_W-1:0]  dir;
    logic [PIOP_W-1:0]  lat;
    logic [PIOP_W-1:0]  odc;
    logic [PIOP_W-1:0]  pin_s1;
    logic [PIOP_W-1:0]  pin_s2;
    logic [PIOP_W-1:0]  pin_lvl;
    logic [PIOP_W-1:0]  pin_out;
    logic [PIOP_W-1:0]  pin_oe;
    logic [PIOP_W-1:0]  periph_in;
    logic [PIOP_CN-1:0] pu;
    logic [PIOP_CN-1:0] cn_s1;
    logic [PIOP_CN-1:0] cn_s2;
    logic [PIOP_CN-1:0] cn_prev;
    logic [PIOP_CN-1:0] cn_flag;
    logic [1:0]         cn_arm;
    logic               irq;
  } piop_state_t;

endpackage

/* File: piop_pins_model.sv */
`timescale 1ns/100ps
module piop_pins_model
  import piop_pkg::*;
(
  // clock
  input  wire logic               clk_sys_i,
  // device side
  input  wire logic [PIOP_W-1:0]  pin_o_i,
  input  wire logic [PIOP_W-1:0]  pin_oe_i,
  input  wire logic [PIOP_CN-1:0] pullup_i,
  output logic      [PIOP_W-1:0]  pin_lvl_o,
  output logic      [PIOP_CN-1:0] cn_o,
  // external drivers
  input  wire logic [PIOP_W-1:0]  ext_val_i,
  input  wire logic [PIOP_W-1:0]  ext_en_i,
  input  wire logic [PIOP_CN-1:0] cn_val_i,
  input  wire logic [PIOP_CN-1:0] cn_en_i
);
  logic [PIOP_W-1:0]  flt_q = '0;
  logic [PIOP_CN-1:0] cflt_q = '0;

  // undriven lines toggle so a stale level never passes
  always @(posedge clk_sys_i) begin
    flt_q  <= ~flt_q;
    cflt_q <= ~cflt_q;
  end

  // the device driver wins; released pins follow outside drivers
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                   | (~pin_oe_i & ~ext_en_i & flt_q);
  assign cn_o = (cn_en_i & cn_val_i) | (~cn_en_i & pullup_i)
              | (~cn_en_i & ~pullup_i & cflt_q);
endmodule

/* File: test_parallel_io_port_change_notify.sv */
`timescale 1ns/100ps
module test_parallel_io_port_change_notify;
  import piop_pkg::*;
  logic               clk_sys_i = 1'b0;
  logic               reset_i = 1'b1;
  piop_sw_t           sw_i = '0;
  piop_periph_t       periph_i = '0;
  logic [PIOP_W-1:0]  analog_cfg_i = '0, ext_val = '0, dir_o, lat_o, odc_o, pin_level_o;
  logic [PIOP_W-1:0]  periph_in_o, pin_i, pin_o, pin_oe_o;
  logic [PIOP_W-1:0]  dir_e, lat_e, odc_e, own, val, oe_e, pin_e;
  logic [PIOP_CN-1:0] cn_irq_en_i = '0, pullup_en_i = '0, cn_clr_i = '0, cn_val = '0;
  logic [PIOP_CN-1:0] cn_i, cn_flag_o, pullup_o, en_e, tog;
  logic               irq_o;
  int                 bad_count = 0;
  int                 checks_done = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  piop_port uut (.clk_sys_i, .reset_i, .sw_i, .analog_cfg_i, .cn_irq_en_i, .pullup_en_i,
    .cn_clr_i, .dir_o, .lat_o, .odc_o, .pin_level_o, .cn_flag_o, .irq_o, .periph_i,
    .periph_in_o, .pin_i, .pin_o, .pin_oe_o, .cn_i, .pullup_o);

  piop_pins_model pins (.clk_sys_i, .pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pullup_i(pullup_o),
    .pin_lvl_o(pin_i), .cn_o(cn_i), .ext_val_i(ext_val), .ext_en_i({PIOP_W{1'b1}}),
    .cn_val_i(cn_val), .cn_en_i({PIOP_CN{1'b1}}));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // k: 0 dir, 1 latch, 2 level path, 3 open drain
  task automatic wr(input int k, input logic [PIOP_W-1:0] d);
    @(negedge clk_sys_i);
    sw_i = {k == 0, k == 1, k == 2, k == 3, d};
    @(negedge clk_sys_i);
    sw_i = '0;
  endtask

  task automatic rst;
    reset_i = 1'b1;
    idle(12);
    chk(dir_o, PIOP_DIR_RST & PIOP_IMPL_MASK);
    chk(pin_oe_o, 16'h0000);
    chk(lat_o, PIOP_LAT_RST);
    chk(irq_o, 1'b0);
    reset_i = 1'b0;
    idle(4);
  endtask

  task automatic conclude;
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'hf50b997e));
    rst();
    for (int i = 0; i < 40; i++) begin
      dir_e = 16'($urandom);
      lat_e = 16'($urandom);
      odc_e = 16'($urandom);
      periph_i = {16'($urandom), 16'($urandom), 16'($urandom)};
      analog_cfg_i = 16'($urandom) & dir_e;
      pullup_en_i = {6'($urandom), 16'($urandom) & dir_e};
      ext_val = 16'($urandom);
      wr(0, dir_e);
      wr(i % 2 + 1, lat_e);
      wr(3, odc_e);
      // settle before reading back
      idle(6);
      own = periph_i.en & periph_i.drive;
      val = (own & periph_i.data) | (~own & lat_e);
      oe_e = (own | ~dir_e) & (~odc_e | ~val);
      pin_e = (oe_e & ~odc_e & val) | (~oe_e & ext_val);
      chk(dir_o, dir_e);
      chk(lat_o, lat_e);
      chk(odc_o, odc_e);
      chk(pin_oe_o, oe_e);
      chk(pin_o & oe_e, oe_e & ~odc_e & val);
      chk(pin_level_o, pin_e & ~analog_cfg_i);
      chk(periph_in_o & ~odc_e, pin_e & ~odc_e & (own | dir_e));
    end
    rst();
    for (int i = 0; i < 20; i++) begin
      en_e = 22'($urandom);
      cn_irq_en_i = en_e;
      pullup_en_i = 22'($urandom);
      tog = (i == 0) ? 22'h3fffff : 22'($urandom);
      cn_val = cn_val ^ tog;
      idle(5);
      chk(cn_flag_o, tog & en_e);
      chk(irq_o, |(tog & en_e));
      chk(pullup_o, pullup_en_i);
      cn_clr_i = '1;
      idle(1);
      cn_clr_i = '0;
      idle(2);
      chk(irq_o, 1'b0);
    end
    conclude();
  end
endmodule
